/* hdl/srs_defines.vh */
`ifndef SRS_DEFINES_VH
`define SRS_DEFINES_VH

// Register indices; byte address is four times the index
`define SRS_IDX_BRK_STATUS   16'hFE00
`define SRS_IDX_RST_CAUSE    16'hFE01
`define SRS_IDX_CFG_ONE      16'hFE02
`define SRS_IDX_BRK_FLAG_CTL 16'hFE03

// Reset cause flag positions
`define SRS_BIT_POR          7
`define SRS_BIT_PIN          6
`define SRS_BIT_WDOG         5
`define SRS_BIT_BAD_OPC      4
`define SRS_BIT_BAD_ADDR     3
`define SRS_BIT_MON_ENTRY    2
`define SRS_BIT_LOW_VOLT     1

// Other field positions
`define SRS_BIT_BRK_STOPWAIT 1
`define SRS_BIT_BRK_CLR_EN   7
`define SRS_BIT_FAST_RECOV   0

// Reset values
`define SRS_CAUSE_RST        8'h80
`define SRS_BRK_CLR_EN_RST   1'b0
`define SRS_FAST_RECOV_RST   1'b0
`define SRS_STOPWAIT_RST     1'b0

// Recovery delays in quad-rate bus clock cycles
`define SRS_SLOW_CYCLES      13'd4096
`define SRS_FAST_CYCLES      13'd32

// Erased reset vector byte
`define SRS_ERASED_BYTE      8'hFF

`endif

/* hdl/srs_recovery_counter.v */
`include "srs_defines.vh"

module srs_recovery_counter (
  input  wire clock,      // Quad-rate bus clock
  input  wire arst_n,     // Async reset, active low
  input  wire clear,      // Hold count at zero
  input  wire fastSel,    // Short recovery selected
  output wire done        // Last cycle of recovery
);

  reg  [12:0] count;
  wire [12:0] limit;

  assign limit = fastSel ? `SRS_FAST_CYCLES : `SRS_SLOW_CYCLES;
  assign done  = ~clear && (count == limit - 13'd1);

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count <= 13'h0000;
    end else if (clear) begin
      count <= 13'h0000;
    end else if (!done) begin
      count <= count + 13'd1;
    end
  end

endmodule

/* hdl/srs_reset_cause.v */
`include "srs_defines.vh"

module srs_reset_cause (
  input  wire       clock,     // System clock
  input  wire       arst_n,    // Power-on reset, active low
  input  wire [7:0] setFlags,  // Cause events, one bit per flag
  input  wire       readClear, // Read access completes
  input  wire [7:0] readMask,  // Bits returned by that read
  output wire [7:0] cause      // Flag register contents
);

  localparam [7:0] RST_VAL = `SRS_CAUSE_RST;

  genvar i;
  generate
    for (i = 1; i < 8; i = i + 1) begin : gFlag
      reg flag;
      always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          flag <= RST_VAL[i];
        end else if (setFlags[i]) begin
          flag <= 1'b1;
        end else if (readClear && readMask[i]) begin
          flag <= 1'b0;
        end
      end
      assign cause[i] = flag;
    end
  endgenerate

  assign cause[0] = 1'b0;

endmodule

/* hdl/srs_top.v */
// Contract
// - Stop entry clears the recovery counter and disables all system clocks.
// - Any peripheral interrupt request ends stop mode.
// - Stacking waits until the selected recovery delay has fully elapsed.
// - A reset or a break also ends stop mode.
// - Double-rate and quad-rate clocks are both gated off in stop.
// - Recovery lasts 4096 quad cycles, or 32 with fast recovery set.
// - Recovery counter held reset from stop until recovery, then times it.
// - Four user registers decoded at FE00, FE01, FE02 and FE03.
// - Seven reset cause flags; reading the register clears them.
// - Power-on reset sets the power-on flag and clears all others.
// - External reset pin sets the external-line flag.
// - Watchdog timeout reset sets the watchdog flag.
// - Illegal opcode reset sets the bad-opcode flag.
// - Opcode fetch from unimplemented address sets the bad-address flag.
// - Monitor entry with erased vectors and high interrupt pin sets flag.
// - Low-voltage inhibit reset sets the low-voltage flag.
// - Break-clear enable is read/write; when zero, break clears blocked.
// - Two-step clears stay protected in break; step two after break works.
// - A flag cleared in break with clearing enabled stays cleared.
//
// Register access over APB was decided locally.

`include "srs_defines.vh"

module srs_top (
  input  wire        clock,          // 250 MHz quad-rate bus clock
  input  wire        arst_n,         // Power-on reset, active low
  input  wire        psel,           // APB select
  input  wire        penable,        // APB enable
  input  wire        pwrite,         // APB write
  input  wire [31:0] paddr,          // APB byte address
  input  wire [31:0] pwdata,         // APB write data
  output reg  [31:0] prdata,         // APB read data
  output reg         pready,         // APB ready
  output reg         pslverr,        // APB error, unmapped address
  input  wire        stopReq,        // STOP instruction executed
  input  wire        irqReq,         // Any peripheral interrupt request
  input  wire        breakIrq,       // Break module interrupt
  input  wire        breakState,     // CPU is in break state
  input  wire        pinRstEvt,      // External reset pin reset
  input  wire        wdogRstEvt,     // Watchdog timeout reset
  input  wire        badOpcRstEvt,   // Illegal opcode reset
  input  wire        badAddrRstEvt,  // Unimplemented address fetch reset
  input  wire        lowVoltRstEvt,  // Low-voltage inhibit reset
  input  wire        monEntryReq,    // Monitor entry attempt after power-on
  input  wire [7:0]  resetVecHi,     // Reset vector high byte
  input  wire [7:0]  resetVecLo,     // Reset vector low byte
  input  wire        irqPinHigh,     // Interrupt pin held high
  output reg         dblClockEn,     // Double-rate clock gate enable
  output reg         quadClockEn,    // Quad-rate clock gate enable
  output reg         stopActive,     // Stop or recovery in progress
  output reg         stackGo,        // Pulse: stacking may begin
  output reg         flagClearAllow  // Peripherals may clear status flags
);

  localparam [2:0] ST_RUN   = 3'b001;
  localparam [2:0] ST_STOP  = 3'b010;
  localparam [2:0] ST_RECOV = 3'b100;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg         fastRecov;
  reg         brkClrEn;
  reg         stopWaitFlag;
  reg  [31:0] next_prdata;

  wire        countDone;
  wire        counterClear;
  wire        monEntryEvt;
  wire        anyRstEvt;
  wire [7:0]  causeSet;
  wire [7:0]  cause;
  wire        clearOk;

  wire        setup;
  wire        access;
  wire        wrDone;
  wire        rdDone;
  wire        addrOk;
  wire [15:0] idx;
  wire        hitBrk;
  wire        hitCause;
  wire        hitCfg;
  wire        hitBfc;
  wire        mapped;

  // Bus phase decode
  assign setup  = psel && !penable;
  assign access = psel && penable && pready;
  assign wrDone = access && pwrite;
  assign rdDone = access && !pwrite;
  assign addrOk = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'b00);
  assign idx    = paddr[17:2];

  assign hitBrk   = addrOk && (idx == `SRS_IDX_BRK_STATUS);
  assign hitCause = addrOk && (idx == `SRS_IDX_RST_CAUSE);
  assign hitCfg   = addrOk && (idx == `SRS_IDX_CFG_ONE);
  assign hitBfc   = addrOk && (idx == `SRS_IDX_BRK_FLAG_CTL);
  assign mapped   = hitBrk || hitCause || hitCfg || hitBfc;

  // Clears blocked in break unless enabled
  assign clearOk = !breakState || brkClrEn;

  // Monitor entry only with erased vector and high interrupt pin
  assign monEntryEvt = monEntryReq &&
                       (resetVecHi == `SRS_ERASED_BYTE) &&
                       (resetVecLo == `SRS_ERASED_BYTE) &&
                       irqPinHigh;

  assign anyRstEvt = pinRstEvt || wdogRstEvt || badOpcRstEvt ||
                     badAddrRstEvt || lowVoltRstEvt || monEntryEvt;

  // Flag layout fixed by bit defines
  assign causeSet[`SRS_BIT_POR]       = 1'b0;
  assign causeSet[`SRS_BIT_PIN]       = pinRstEvt;
  assign causeSet[`SRS_BIT_WDOG]      = wdogRstEvt;
  assign causeSet[`SRS_BIT_BAD_OPC]   = badOpcRstEvt;
  assign causeSet[`SRS_BIT_BAD_ADDR]  = badAddrRstEvt;
  assign causeSet[`SRS_BIT_MON_ENTRY] = monEntryEvt;
  assign causeSet[`SRS_BIT_LOW_VOLT]  = lowVoltRstEvt;
  assign causeSet[0]                  = 1'b0;

  srs_reset_cause uCause (
    .clock     (clock),
    .arst_n    (arst_n),
    .setFlags  (causeSet),
    .readClear (rdDone && hitCause && clearOk),
    .readMask  (prdata[7:0]),
    .cause     (cause)
  );

  // Counter held clear outside recovery
  assign counterClear = (state != ST_RECOV);

  srs_recovery_counter uCount (
    .clock   (clock),
    .arst_n  (arst_n),
    .clear   (counterClear),
    .fastSel (fastRecov),
    .done    (countDone)
  );

  // Stop sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (stopReq) begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (anyRstEvt) begin
          next_state = ST_RUN;
        end else if (irqReq || breakIrq) begin
          next_state = ST_RECOV;
        end
      end
      ST_RECOV: begin
        if (anyRstEvt) begin
          next_state = ST_RUN;
        end else if (countDone) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state       <= ST_RUN;
      dblClockEn  <= 1'b1;
      quadClockEn <= 1'b1;
      stopActive  <= 1'b0;
      stackGo     <= 1'b0;
    end else begin
      state       <= next_state;
      dblClockEn  <= (next_state == ST_RUN);
      quadClockEn <= (next_state == ST_RUN);
      stopActive  <= (next_state != ST_RUN);
      stackGo     <= (state == ST_RECOV) && countDone &&
                     !anyRstEvt;
    end
  end

  // Break-time clear permission for peripheral flags
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flagClearAllow <= 1'b1;
    end else begin
      flagClearAllow <= !breakState || brkClrEn;
    end
  end

  // Writable controls
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fastRecov <= `SRS_FAST_RECOV_RST;
      brkClrEn  <= `SRS_BRK_CLR_EN_RST;
    end else begin
      if (wrDone && hitCfg) begin
        fastRecov <= pwdata[`SRS_BIT_FAST_RECOV];
      end
      if (wrDone && hitBfc) begin
        brkClrEn <= pwdata[`SRS_BIT_BRK_CLR_EN];
      end
    end
  end

  // Break during stop flag; write zero clears, set wins
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stopWaitFlag <= `SRS_STOPWAIT_RST;
    end else if ((state == ST_STOP) && breakIrq) begin
      stopWaitFlag <= 1'b1;
    end else if (wrDone && hitBrk && clearOk &&
                 !pwdata[`SRS_BIT_BRK_STOPWAIT]) begin
      stopWaitFlag <= 1'b0;
    end
  end

  // Read mux, sampled in the setup cycle
  always @* begin
    next_prdata = 32'h0000_0000;
    if (hitBrk) begin
      next_prdata[`SRS_BIT_BRK_STOPWAIT] = stopWaitFlag;
    end else if (hitCause) begin
      next_prdata[7:0] = cause;
    end else if (hitCfg) begin
      next_prdata[`SRS_BIT_FAST_RECOV] = fastRecov;
    end else if (hitBfc) begin
      next_prdata[`SRS_BIT_BRK_CLR_EN] = brkClrEn;
    end
  end

  // Zero-wait slave: ready in the first access cycle
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

endmodule

/* verif/srs_cpu_model.sv */
module srs_cpu_model (
  input  logic clock,   // Clock
  input  logic arst_n,  // Reset
  input  logic goStop,  // Execute stop
  input  logic goWake,  // Peripheral raises request
  input  logic stackGo, // Stacking begins
  output logic stopReq, // Stop pulse
  output logic irqReq   // Peripheral request
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stopReq <= 1'b0;
      irqReq <= 1'b0;
    end else begin
      stopReq <= goStop;
      // Request held until serviced
      if (goWake) begin
        irqReq <= 1'b1;
      end else if (stackGo) begin
        irqReq <= 1'b0;
      end
    end
  end
endmodule

/* verif/srs_top_monitor.sv */
module srs_top_monitor (
  input logic        clock,         // Clock
  input logic        arst_n,        // Reset
  input logic        psel,          // Select
  input logic        penable,       // Enable
  input logic [31:0] paddr,         // Address
  input logic        pready,        // Ready
  input logic        pslverr,       // Error
  input logic        stopReq,       // Stop request
  input logic        breakState,    // Break state
  input logic        pinRstEvt,     // Pin reset
  input logic        dblClockEn,    // Clock gate
  input logic        quadClockEn,   // Clock gate
  input logic        stopActive,    // Stop or recovery
  input logic        stackGo,       // Stacking pulse
  input logic        flagClearAllow // Clears allowed
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_enter;
    stopReq && !stopActive |=> stopActive && !dblClockEn && !quadClockEn;
  endproperty
  a_enter: assert property (p_enter) else $error("stop entry wrong");
  property p_gated;
    stopActive |-> !dblClockEn && !quadClockEn;
  endproperty
  a_gated: assert property (p_gated) else $error("clock not gated");
  property p_stack_end;
    stackGo |-> dblClockEn && quadClockEn && !stopActive;
  endproperty
  a_stack_end: assert property (p_stack_end) else $error("bad wake");
  property p_stack_pulse;
    stackGo |=> !stackGo;
  endproperty
  a_stack_pulse: assert property (p_stack_pulse) else $error("long");
  property p_hold;
    stackGo |-> $past(stopActive, 32);
  endproperty
  a_hold: assert property (p_hold) else $error("recovery short");
  property p_abort;
    stopActive && pinRstEvt |=> !stopActive && !stackGo;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_setup;
    psel && !penable |=> pready;
  endproperty
  a_setup: assert property (p_setup) else $error("no ready");
  property p_once;
    pready |=> !pready;
  endproperty
  a_once: assert property (p_once) else $error("ready too long");
  property p_err;
    pready |-> pslverr == !(paddr inside {32'h0003F800, 32'h0003F804,
                                         32'h0003F808, 32'h0003F80C});
  endproperty
  a_err: assert property (p_err) else $error("decode wrong");
  property p_clr;
    !breakState |=> flagClearAllow;
  endproperty
  a_clr: assert property (p_clr) else $error("clear blocked");
  c_wake: cover property (stackGo);
  c_err: cover property (pready && pslverr);
  c_abort: cover property (stopActive && pinRstEvt);
endmodule

bind srs_top srs_top_monitor i_mon (.clock, .arst_n, .psel, .penable,
  .paddr, .pready, .pslverr, .stopReq, .breakState, .pinRstEvt,
  .dblClockEn, .quadClockEn, .stopActive, .stackGo, .flagClearAllow);

/* verif/test_stop_recovery_reset_status.sv */
module test_stop_recovery_reset_status;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] BS = 32'h0003F800, RC = 32'h0003F804;
  localparam logic [31:0] CF = 32'h0003F808, BF = 32'h0003F80C;
  logic clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, breakIrq = 1'b0, breakState = 1'b0;
  logic goStop = 1'b0, goWake = 1'b0, irqPinHigh = 1'b1;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic [7:0] resetVecHi = 8'hFF, resetVecLo = 8'hFF;
  logic [5:0] ev = 6'h00;
  logic pready, pslverr, stopReq, irqReq, dblClockEn, quadClockEn;
  logic stopActive, stackGo, flagClearAllow;
  int mismatches = 0, checks = 0, bits[6] = '{6, 5, 4, 3, 1, 2};
  always #2 clock = ~clock;
  srs_top i_dut (.clock, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .stopReq, .irqReq, .breakIrq,
    .breakState, .pinRstEvt(ev[0]), .wdogRstEvt(ev[1]),
    .badOpcRstEvt(ev[2]), .badAddrRstEvt(ev[3]), .lowVoltRstEvt(ev[4]),
    .monEntryReq(ev[5]), .resetVecHi, .resetVecLo, .irqPinHigh,
    .dblClockEn, .quadClockEn, .stopActive, .stackGo, .flagClearAllow);
  srs_cpu_model i_cpu (.clock, .arst_n, .goStop, .goWake, .stackGo,
    .stopReq, .irqReq);
  task stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g) begin
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      mismatches++;
    end
  endtask
  task automatic acc(input logic w, input logic [31:0] a,
                     input logic [7:0] d, input logic er);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      stop_test();
    end
    if (!w) chk("rdata", d, prdata[7:0]);
    chk("slverr", er, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task pulse(input logic [5:0] v);
    ev <= v;
    @(posedge clock);
    ev <= 6'h00;
    @(posedge clock);
  endtask
  task automatic sleep(input logic brk, input int exp);
    int n;
    goStop <= 1'b1;
    @(posedge clock);
    goStop <= 1'b0;
    repeat (3) @(posedge clock);
    chk("gates", 3'b100, {stopActive, dblClockEn, quadClockEn});
    if (brk) breakIrq <= 1'b1;
    else goWake <= 1'b1;
    @(posedge clock);
    n = 1;
    breakIrq <= 1'b0;
    goWake <= 1'b0;
    while (stackGo !== 1'b1 && n < 5000) begin
      @(posedge clock);
      n++;
    end
    chk("delay", exp, n);
    chk("wake", 3'b011, {stopActive, dblClockEn, quadClockEn});
  endtask
  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    acc(0, RC, 8'h80, 0);
    acc(0, RC, 8'h00, 0);
    acc(0, BF, 8'h00, 0);
    acc(0, 32'h0003F810, 8'h00, 1);
    acc(1, 32'h0003F810, 8'h00, 1);
    for (int i = 0; i < 6; i++) begin
      pulse(6'h01 << i);
      acc(0, RC, 8'h01 << bits[i], 0);
    end
    resetVecHi <= 8'h12;
    pulse(6'h20);
    acc(0, RC, 8'h00, 0);
    resetVecHi <= 8'hFF;
    resetVecLo <= 8'h34;
    pulse(6'h20);
    acc(0, RC, 8'h00, 0);
    resetVecLo <= 8'hFF;
    irqPinHigh <= 1'b0;
    pulse(6'h20);
    acc(0, RC, 8'h00, 0);
    irqPinHigh <= 1'b1;
    breakState <= 1'b1;
    pulse(6'h01);
    chk("allow", 0, flagClearAllow);
    acc(0, RC, 8'h40, 0);
    acc(0, RC, 8'h40, 0);
    acc(1, BF, 8'h80, 0);
    acc(0, BF, 8'h80, 0);
    acc(0, RC, 8'h40, 0);
    breakState <= 1'b0;
    acc(0, RC, 8'h00, 0);
    acc(1, BF, 8'h00, 0);
    acc(1, CF, 8'h01, 0);
    sleep(0, 35);
    sleep(1, 34);
    breakState <= 1'b1;
    acc(1, BS, 8'h00, 0);
    acc(0, BS, 8'h02, 0);
    breakState <= 1'b0;
    acc(0, BS, 8'h02, 0);
    acc(1, BS, 8'h00, 0);
    acc(0, BS, 8'h00, 0);
    acc(1, CF, 8'h00, 0);
    sleep(0, 4099);
    goStop <= 1'b1;
    @(posedge clock);
    goStop <= 1'b0;
    repeat (3) @(posedge clock);
    pulse(6'h01);
    @(posedge clock);
    chk("abort", 3'b011, {stopActive, dblClockEn, quadClockEn});
    acc(0, RC, 8'h40, 0);
    // Reset event a few cycles into a slow recovery
    goStop <= 1'b1;
    @(posedge clock);
    goStop <= 1'b0;
    repeat (3) @(posedge clock);
    goWake <= 1'b1;
    @(posedge clock);
    goWake <= 1'b0;
    repeat (4) @(posedge clock);
    chk("recov", 3'b100, {stopActive, dblClockEn, quadClockEn});
    pulse(6'h01);
    @(posedge clock);
    chk("abort2", 3'b011, {stopActive, dblClockEn, quadClockEn});
    chk("nostack", 0, stackGo);
    acc(0, RC, 8'h40, 0);
    // Second power-on reset while the bad-opcode flag and fast recovery are set
    acc(1, CF, 8'h01, 0);
    pulse(6'h04);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    chk("rst", 3'b011, {stopActive, dblClockEn, quadClockEn});
    acc(0, RC, 8'h80, 0);
    acc(0, CF, 8'h00, 0);
    stop_test();
  end
endmodule
